// ---- design/msc_controller.sv ----
// Controlling end: strobe source, data source and alignment sequence
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_controller #(
  parameter int STROBE_DIV = 16,
  parameter int WORD_DIV   = 4,
  parameter int SYNC_LEN   = 4,
  parameter int SETTLE_LEN = 64
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  msc_link_if.ctl          link,
  input  wire logic        start_in,
  input  wire logic        pll_mode_in,
  input  wire logic [15:0] word_in,
  output logic             busy_out,
  output logic             tx_enable_out
);
  // ==========================================================
  // State
  msc_pkg::msc_ctl_state_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0]  str_cnt_reg, str_cnt_next;
  logic [7:0]  wd_cnt_reg, wd_cnt_next;
  logic        pll_reg, pll_next;
  logic        strobe_reg, strobe_next;
  logic        sync_reg, sync_next;
  logic        wr_reg, wr_next;
  logic [7:0]  addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] data_reg, data_next;
  logic        vld_reg, vld_next;
  logic        tx_reg, tx_next;

  // Next values of strobe, data and sequence
  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    pll_next   = pll_reg;
    sync_next  = sync_reg;
    wr_next    = 1'b0;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    tx_next    = tx_reg;
    data_next  = data_reg;
    vld_next   = 1'b0;

    // Strobe from the same clock as the converter clock; an inverted
    // clock feed is the board's fix for the sampling window
    str_cnt_next = (str_cnt_reg == 8'(STROBE_DIV - 1)) ? 8'h00 : str_cnt_reg + 8'h01;
    strobe_next  = (str_cnt_reg == 8'(STROBE_DIV - 1));

    // Words at the converter's read rate; phase relation is free
    wd_cnt_next = (wd_cnt_reg == 8'(WORD_DIV - 1)) ? 8'h00 : wd_cnt_reg + 8'h01;
    if (wd_cnt_reg == 8'(WORD_DIV - 1))
    begin
      data_next = word_in;
      vld_next  = 1'b1;
    end

    case (st_reg)
      msc_pkg::MSC_IDLE:
        if (start_in)
        begin
          pll_next = pll_mode_in;
          st_next  = msc_pkg::MSC_WR_SRC;
        end
      msc_pkg::MSC_WR_SRC:
      begin
        // Strobe (pin or internal) chosen as divider alignment source
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_SYNCSRC;
        wdata_next = 16'h0001 << `MSC_BIT_SYNC_SEL;
        st_next    = msc_pkg::MSC_WR_PLL;
      end
      msc_pkg::MSC_WR_PLL:
      begin
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_PLL;
        wdata_next = (16'(pll_reg) << `MSC_BIT_PLL_ENA) |
                     (16'(pll_reg) << `MSC_BIT_NDIVSYNC_ENA);
        st_next    = msc_pkg::MSC_WR_ENA;
      end
      msc_pkg::MSC_WR_ENA:
      begin
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_CFG0;
        wdata_next = 16'h0001 << `MSC_BIT_CLKDIV_ENA;
        cnt_next   = 16'h0000;
        st_next    = pll_reg ? msc_pkg::MSC_SYN_HI : msc_pkg::MSC_SETTLE;
      end
      msc_pkg::MSC_SYN_HI:
      begin
        // A single rising edge is enough to reset the feedback divider
        sync_next = 1'b1;
        cnt_next  = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(SYNC_LEN - 1))
        begin
          cnt_next = 16'h0000;
          st_next  = msc_pkg::MSC_SYN_LO;
        end
      end
      msc_pkg::MSC_SYN_LO:
      begin
        sync_next = 1'b0;
        cnt_next  = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(SYNC_LEN - 1))
          st_next = msc_pkg::MSC_WR_NDS;
      end
      msc_pkg::MSC_WR_NDS:
      begin
        // Keep PLL on but stop later sync edges resetting it
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_PLL;
        wdata_next = 16'h0001 << `MSC_BIT_PLL_ENA;
        cnt_next   = 16'h0000;
        st_next    = msc_pkg::MSC_SETTLE;
      end
      msc_pkg::MSC_SETTLE:
      begin
        // Let several strobes realign divider and pointers
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(SETTLE_LEN - 1))
          st_next = msc_pkg::MSC_WR_CLR;
      end
      msc_pkg::MSC_WR_CLR:
      begin
        // Clear alarms raised before alignment took hold
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_ALARM;
        wdata_next = 16'h0000;
        cnt_next   = 16'h0000;
        st_next    = msc_pkg::MSC_RD_ALM;
      end
      msc_pkg::MSC_RD_ALM:
      begin
        // Hold the address long enough for several read ticks
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(SETTLE_LEN - 1))
          st_next = msc_pkg::MSC_CHECK;
      end
      msc_pkg::MSC_CHECK:
        if (((link.reg_rdata & `MSC_ALM_MASK) != 16'h0000) || link.alarm)
          st_next = msc_pkg::MSC_WR_ENA;
        else
          st_next = msc_pkg::MSC_WR_DIS;
      msc_pkg::MSC_WR_DIS:
      begin
        // Last step: later strobes must not move the divider
        wr_next    = 1'b1;
        addr_next  = `MSC_ADDR_CFG0;
        wdata_next = `MSC_RST_CFG;
        st_next    = msc_pkg::MSC_RUN;
      end
      msc_pkg::MSC_RUN:
      begin
        tx_next = 1'b1;
        // An alarm stops transmit and repeats the whole procedure
        if (link.alarm)
        begin
          tx_next = 1'b0;
          st_next = msc_pkg::MSC_WR_SRC;
        end
      end
      default:
        st_next = msc_pkg::MSC_IDLE;
    endcase
    if (st_next != msc_pkg::MSC_RUN)
      tx_next = 1'b0;
  end

  // Register stage of the controlling end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_reg      <= msc_pkg::MSC_IDLE;
      cnt_reg     <= 16'h0000;
      str_cnt_reg <= 8'h00;
      wd_cnt_reg  <= 8'h00;
      pll_reg     <= 1'b0;
      strobe_reg  <= 1'b0;
      sync_reg    <= 1'b0;
      wr_reg      <= 1'b0;
      addr_reg    <= 8'h00;
      wdata_reg   <= `MSC_RST_CFG;
      data_reg    <= `MSC_RST_WORD;
      vld_reg     <= 1'b0;
      tx_reg      <= 1'b0;
    end
    else
    begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      str_cnt_reg <= str_cnt_next;
      wd_cnt_reg  <= wd_cnt_next;
      pll_reg     <= pll_next;
      strobe_reg  <= strobe_next;
      sync_reg    <= sync_next;
      wr_reg      <= wr_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      data_reg    <= data_next;
      vld_reg     <= vld_next;
      tx_reg      <= tx_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.output_strobe = strobe_reg;
  assign link.sync_in       = sync_reg;
  assign link.word_data     = data_reg;
  assign link.word_valid    = vld_reg;
  assign link.reg_wr        = wr_reg;
  assign link.reg_addr      = addr_reg;
  assign link.reg_wdata     = wdata_reg;
  assign busy_out           = (st_reg != msc_pkg::MSC_IDLE) && (st_reg != msc_pkg::MSC_RUN);
  assign tx_enable_out      = tx_reg;
endmodule

// ---- design/msc_defs.svh ----
// Register offsets, field positions and reset values of the sync control block
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_ADDR_CFG0     8'h00
`define MSC_ADDR_ALARM    8'h05
`define MSC_ADDR_PLL      8'h18
`define MSC_ADDR_SYNCSRC  8'h20
`define MSC_BIT_CLKDIV_ENA   2
`define MSC_BIT_NDIVSYNC_ENA 11
`define MSC_BIT_PLL_ENA      0
`define MSC_BIT_SYNC_SEL     0
`define MSC_BIT_ALM_OVF      0
`define MSC_BIT_ALM_UNF      1
`define MSC_RST_CFG       16'h0000
`define MSC_RST_WORD      16'h0000
`define MSC_ALM_MASK      16'h0003
`endif

// ---- design/msc_device.sv ----
// Converter end: divider alignment, feedback divider sync and input FIFO
//
// Contract
// - Dual-sync mode: every device gets output strobe
// - FIFO absorbs path delays, equal read instant
// - Strobe sampled by converter clock, same domain
// - Source may invert clock to meet sampling
// - Controller selects strobe as alignment source
// - Controller checks alarms after alignment
// - Controller clears divider alignment enable last
// - PLL mode derives strobe internally
// - Feedback enable lets sync reset dividers
// - Sync rising edge resets feedback divider
// - One edge suffices; clear enable afterwards
// - No timing needed besides sync window
// - Bit 2 enables clock divider realignment
// - Bit 11 enables feedback divider sync
// - Clock or alarm loss forces full realignment; clock loss is not detected, alarm at MSC_CHECK restarts from MSC_WR_ENA
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_device #(
  parameter int FB_DIV      = 16,
  parameter int CLK_DIV     = 4,
  parameter int FIFO_DEPTH  = 8,
  parameter int FIFO_OFFSET = 4
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  msc_link_if.dev          link,
  output logic [15:0]      sample_out,
  output logic             sample_valid_out,
  output logic             div_phase_out
);
  localparam int AW = $clog2(FIFO_DEPTH);

  // ==========================================================
  // Pin synchronisers
  logic str_s1_reg, str_s2_reg, str_s3_reg;
  logic syn_s1_reg, syn_s2_reg, syn_s3_reg;
  logic str_rise, syn_rise;

  // Strobe and sync arrive on pins, so two flops before any logic
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      str_s1_reg <= 1'b0;
      str_s2_reg <= 1'b0;
      str_s3_reg <= 1'b0;
      syn_s1_reg <= 1'b0;
      syn_s2_reg <= 1'b0;
      syn_s3_reg <= 1'b0;
    end
    else
    begin
      str_s1_reg <= link.output_strobe;
      str_s2_reg <= str_s1_reg;
      str_s3_reg <= str_s2_reg;
      syn_s1_reg <= link.sync_in;
      syn_s2_reg <= syn_s1_reg;
      syn_s3_reg <= syn_s2_reg;
    end
  end

  // Edge detectors look only at second and third stage
  assign str_rise = str_s2_reg & ~str_s3_reg;
  assign syn_rise = syn_s2_reg & ~syn_s3_reg;

  // ==========================================================
  // Registers, dividers and FIFO state
  logic [15:0]   cfg0_reg, cfg0_next;
  logic [15:0]   pll_reg, pll_next;
  logic [15:0]   src_reg, src_next;
  logic [15:0]   alm_reg, alm_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic          alarm_reg, alarm_next;
  logic [7:0]    fb_cnt_reg, fb_cnt_next;
  logic [7:0]    div_cnt_reg, div_cnt_next;
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [15:0]   smp_reg, smp_next;
  logic          smp_vld_reg, smp_vld_next;
  logic [15:0]   mem [FIFO_DEPTH];
  logic          mem_we;
  logic          int_strobe, sel_strobe, align, rd_tick;

  // Next-state logic for the converter end except the pin synchronisers
  always_comb
  begin
    cfg0_next    = cfg0_reg;
    pll_next     = pll_reg;
    src_next     = src_reg;
    alm_next     = alm_reg;
    wr_ptr_next  = wr_ptr_reg;
    rd_ptr_next  = rd_ptr_reg;
    smp_next     = smp_reg;
    smp_vld_next = 1'b0;
    mem_we       = 1'b0;

    // Register writes; alarm bits clear where a 0 is written
    if (link.reg_wr)
    begin
      if (link.reg_addr == `MSC_ADDR_CFG0)
        cfg0_next = link.reg_wdata;
      else if (link.reg_addr == `MSC_ADDR_PLL)
        pll_next = link.reg_wdata;
      else if (link.reg_addr == `MSC_ADDR_SYNCSRC)
        src_next = link.reg_wdata;
      else if (link.reg_addr == `MSC_ADDR_ALARM)
        alm_next = alm_reg & link.reg_wdata;
    end

    // Register read decode, unmapped offsets read zero
    if (link.reg_addr == `MSC_ADDR_CFG0)
      rdata_next = cfg0_reg;
    else if (link.reg_addr == `MSC_ADDR_PLL)
      rdata_next = pll_reg;
    else if (link.reg_addr == `MSC_ADDR_SYNCSRC)
      rdata_next = src_reg;
    else if (link.reg_addr == `MSC_ADDR_ALARM)
      rdata_next = alm_reg;
    else
      rdata_next = 16'h0000;

    // Feedback divider free-runs; its wrap is the internal strobe
    int_strobe = (fb_cnt_reg == 8'(FB_DIV - 1));
    fb_cnt_next = int_strobe ? 8'h00 : fb_cnt_reg + 8'h01;
    // Only a sync edge with the feedback enable set resets it
    if (pll_reg[`MSC_BIT_NDIVSYNC_ENA] && syn_rise)
      fb_cnt_next = 8'h00;

    // PLL mode uses its own strobe, else the pin strobe
    sel_strobe = pll_reg[`MSC_BIT_PLL_ENA] ? int_strobe : str_rise;
    // With enable clear no edge touches the divider phase
    align = cfg0_reg[`MSC_BIT_CLKDIV_ENA] &&
            (src_reg[`MSC_BIT_SYNC_SEL] ? sel_strobe : syn_rise);

    // Clock divider sets the FIFO read instant
    rd_tick = (div_cnt_reg == 8'(CLK_DIV - 1));
    div_cnt_next = rd_tick ? 8'h00 : div_cnt_reg + 8'h01;

    if (align)
    begin
      // Pointers restart a fixed distance apart on every device
      div_cnt_next = 8'h00;
      wr_ptr_next  = '0;
      rd_ptr_next  = AW'(FIFO_DEPTH - FIFO_OFFSET);
    end
    else
    begin
      // Write side takes words whenever the source sends them and the FIFO is not full
      if (link.word_valid)
      begin
        if (wr_ptr_reg + AW'(1) == rd_ptr_reg)
          alm_next[`MSC_BIT_ALM_OVF] = 1'b1;
        else
        begin
          mem_we      = 1'b1;
          wr_ptr_next = wr_ptr_reg + AW'(1);
        end
      end
      // Read side runs on the divider, independent of arrival delay
      if (rd_tick)
      begin
        if (rd_ptr_reg == wr_ptr_reg)
          alm_next[`MSC_BIT_ALM_UNF] = 1'b1;
        else
        begin
          smp_next     = mem[rd_ptr_reg];
          smp_vld_next = 1'b1;
          rd_ptr_next  = rd_ptr_reg + AW'(1);
        end
      end
    end

    // Alarm pin mirrors any sticky alarm bit
    alarm_next = |(alm_next & `MSC_ALM_MASK);
  end

  // Register stage for converter-end state except synchronisers and FIFO storage
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cfg0_reg    <= `MSC_RST_CFG;
      pll_reg     <= `MSC_RST_CFG;
      src_reg     <= `MSC_RST_CFG;
      alm_reg     <= `MSC_RST_CFG;
      rdata_reg   <= `MSC_RST_CFG;
      alarm_reg   <= 1'b0;
      fb_cnt_reg  <= 8'h00;
      div_cnt_reg <= 8'h00;
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      smp_reg     <= `MSC_RST_WORD;
      smp_vld_reg <= 1'b0;
    end
    else
    begin
      cfg0_reg    <= cfg0_next;
      pll_reg     <= pll_next;
      src_reg     <= src_next;
      alm_reg     <= alm_next;
      rdata_reg   <= rdata_next;
      alarm_reg   <= alarm_next;
      fb_cnt_reg  <= fb_cnt_next;
      div_cnt_reg <= div_cnt_next;
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      smp_reg     <= smp_next;
      smp_vld_reg <= smp_vld_next;
    end
  end

  // FIFO storage has no reset; the first FIFO_OFFSET reads after alignment take old entries
  always_ff @(posedge clk_in)
  begin
    if (mem_we)
      mem[wr_ptr_reg] <= link.word_data;
  end

  // ==========================================================
  // Outputs
  assign link.reg_rdata   = rdata_reg;
  assign link.alarm       = alarm_reg;
  assign sample_out       = smp_reg;
  assign sample_valid_out = smp_vld_reg;
  assign div_phase_out    = (div_cnt_reg == 8'h00);  // Phase marker for alignment checks
endmodule

// ---- design/msc_link_if.sv ----
// Link between the converter end and the controlling clock source and data source
`timescale 1ns/10ps
interface msc_link_if;
  logic        output_strobe;
  logic        sync_in;
  logic [15:0] word_data;
  logic        word_valid;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        alarm;

  modport dev (
    input  output_strobe, sync_in, word_data, word_valid, reg_wr, reg_addr, reg_wdata,
    output reg_rdata, alarm
  );
  modport ctl (
    output output_strobe, sync_in, word_data, word_valid, reg_wr, reg_addr, reg_wdata,
    input  reg_rdata, alarm
  );
endinterface

// ---- design/msc_pkg.sv ----
// Shared types of the sync control block
package msc_pkg;
  // Alignment sequence states of the controlling end
  typedef enum logic [3:0] {
    MSC_IDLE   = 4'b0000,
    MSC_WR_SRC = 4'b0001,
    MSC_WR_PLL = 4'b0010,
    MSC_WR_ENA = 4'b0011,
    MSC_SYN_HI = 4'b0100,
    MSC_SYN_LO = 4'b0101,
    MSC_WR_NDS = 4'b0110,
    MSC_SETTLE = 4'b0111,
    MSC_WR_CLR = 4'b1000,
    MSC_RD_ALM = 4'b1001,
    MSC_CHECK  = 4'b1010,
    MSC_WR_DIS = 4'b1011,
    MSC_RUN    = 4'b1100
  } msc_ctl_state_t;
endpackage

// ---- dv/msc_link_checker.sv ----
// Concurrent checks on the link between the controlling end and the converter end
`timescale 1ns/10ps
module msc_link_checker (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        output_strobe,
  input wire logic        sync_in,
  input wire logic [15:0] word_data,
  input wire logic        word_valid,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        alarm
);
  // ==========================================================
  // Clocking and properties
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Strobe is a lone pulse with at least 8 low cycles after it; the device acts on its rising edge only
  property p_strobe_gap;
    output_strobe |=> (!output_strobe) [*8];
  endproperty
  property p_word_gap;
    word_valid |=> (!word_valid) [*3];
  endproperty
  property p_sync_pulse;
    $rose(sync_in) |-> sync_in [*4] ##1 !sync_in;
  endproperty
  property p_src_sel;
    (reg_wr && reg_addr == 8'h20) |-> reg_wdata[0];
  endproperty
  property p_nds_pll;
    (reg_wr && reg_addr == 8'h18 && reg_wdata[11]) |-> reg_wdata[0];
  endproperty
  property p_cfg0_val;
    (reg_wr && reg_addr == 8'h00) |-> (reg_wdata == 16'h0004 || reg_wdata == 16'h0000);
  endproperty
  // Readback only when the address is held a cycle after the write
  property p_readback;
    (reg_wr && reg_addr inside {8'h00, 8'h18, 8'h20}) ##1 ($stable(reg_addr) && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_unmapped;
    !(reg_addr inside {8'h00, 8'h05, 8'h18, 8'h20}) |=> reg_rdata == 16'h0000;
  endproperty
  // Read data lags the alarm register by one cycle, so it pairs with last cycle's pin
  property p_alarm_pin;
    $past(reg_addr) == 8'h05 |-> $past(alarm) == (reg_rdata[1:0] != 2'b00);
  endproperty
  property p_nds_clear;
    $fell(sync_in) |-> ##[1:8] (reg_wr && reg_addr == 8'h18 && !reg_wdata[11]);
  endproperty

  // ==========================================================
  // Assertions
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe pulse too long");
  a_word_gap: assert property (p_word_gap) else $error("word valid too dense");
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse length wrong");
  a_src_sel: assert property (p_src_sel) else $error("strobe not selected");
  a_nds_pll: assert property (p_nds_pll) else $error("feedback sync without pll");
  a_cfg0_val: assert property (p_cfg0_val) else $error("bad cfg0 value");
  a_readback: assert property (p_readback) else $error("register readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin mismatch");
  a_nds_clear: assert property (p_nds_clear) else $error("feedback sync left on");

  // ==========================================================
  // Coverage of the main scenarios
  c_sync: cover property ($rose(sync_in));
  c_alarm_clear: cover property (reg_wr && reg_addr == 8'h05);
  c_cfg0_off: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata == 16'h0000);
endmodule

// ---- dv/multi_converter_sync_control_tb_top.sv ----
// Self-checking bench: controlling end and converter end joined by the link
`timescale 1ns/10ps
module multi_converter_sync_control_tb_top;
  localparam int CLK_DIV = 4;
  logic        clk_in = 1'b0;
  logic        sys_rst_in;
  logic        start_in;
  logic        pll_mode_in;
  logic [15:0] word_in;
  logic        busy_out;
  logic        tx_enable_out;
  logic [15:0] sample_out;
  logic        sample_valid_out;
  logic        div_phase_out;
  logic [15:0] cfg0_last = 16'hFFFF;
  logic [15:0] pll_last = 16'hFFFF;
  logic [15:0] src_last = 16'hFFFF;
  logic        sync_prev = 1'b0;
  int          sync_rises = 0;
  int          bad_count = 0;
  int          compares = 0;
  int          m;

  // ==========================================================
  // Structure
  msc_link_if link ();
  msc_controller #(.SETTLE_LEN(8)) msc_controller_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link), .start_in(start_in),
    .pll_mode_in(pll_mode_in), .word_in(word_in), .busy_out(busy_out),
    .tx_enable_out(tx_enable_out)
  );
  msc_device msc_device_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link), .sample_out(sample_out),
    .sample_valid_out(sample_valid_out), .div_phase_out(div_phase_out)
  );
  msc_link_checker msc_link_checker_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .output_strobe(link.output_strobe),
    .sync_in(link.sync_in), .word_data(link.word_data), .word_valid(link.word_valid),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .alarm(link.alarm)
  );

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  // Record the last CFG0, PLL and SYNCSRC writes and sync rising edges seen on the link
  always @(posedge clk_in)
  begin
    if (link.reg_wr === 1'b1 && link.reg_addr === 8'h00)
      cfg0_last <= link.reg_wdata;
    if (link.reg_wr === 1'b1 && link.reg_addr === 8'h18)
      pll_last <= link.reg_wdata;
    if (link.reg_wr === 1'b1 && link.reg_addr === 8'h20)
      src_last <= link.reg_wdata;
    if (link.sync_in === 1'b1 && sync_prev === 1'b0)
      sync_rises <= sync_rises + 1;
    sync_prev <= link.sync_in;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Inputs always move a fixed 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  // ==========================================================
  // Scenarios
  // Reset, also used in mid-run: tx, busy, alarm and read data must come back clean
  task automatic do_reset();
    sys_rst_in = 1'b1;
    step(20);
    check("tx in reset", {15'h0, tx_enable_out}, 16'h0000);
    check("busy in reset", {15'h0, busy_out}, 16'h0000);
    check("alarm in reset", {15'h0, link.alarm}, 16'h0000);
    check("rdata in reset", link.reg_rdata, 16'h0000);
    sys_rst_in = 1'b0;
  endtask

  // Full alignment; bounded wait since settle lengths are shortened
  task automatic t_align(input logic pll);
    int n;
    int rises0;
    rises0 = sync_rises;
    pll_mode_in = pll;
    start_in = 1'b1;
    step(1);
    start_in = 1'b0;
    step(1);
    check("busy at start", {15'h0, busy_out}, 16'h0001);
    n = 0;
    while (tx_enable_out !== 1'b1 && n < 3000)
    begin
      step(1);
      n++;
    end
    check("tx enable", {15'h0, tx_enable_out}, 16'h0001);
    check("busy in run", {15'h0, busy_out}, 16'h0000);
    check("alarm in run", {15'h0, link.alarm}, 16'h0000);
    check("cfg0 final", cfg0_last, 16'h0000);
    check("pll final", pll_last, {15'h0, pll});
    check("sync source", src_last, 16'h0001);
    check("sync edges", 16'(sync_rises - rises0), pll ? 16'h0001 : 16'h0000);
  endtask

  // Divider count must hit zero three edges after each strobe, enables cleared
  task automatic t_phase();
    int k;
    logic [3:0] hist;
    hist = 4'h0;
    for (k = 0; k < 64; k++)
    begin
      step(1);
      hist = {hist[2:0], link.output_strobe};
      if (hist[3] === 1'b1)
        check("div phase", {15'h0, div_phase_out}, 16'h0001);
    end
  endtask

  // Steady words must come out once per divider period with no alarm
  task automatic t_data(input logic [15:0] w);
    int k;
    int v;
    v = 0;
    word_in = w;
    step(40);
    for (k = 0; k < 32; k++)
    begin
      step(1);
      if (sample_valid_out === 1'b1)
      begin
        v++;
        check("sample", sample_out, w);
      end
    end
    check("reads", 16'(v), 16'(32 / CLK_DIV));
    check("alarm after data", {15'h0, link.alarm}, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence: bypass mode, then a mid-run reset and pll mode
  initial
  begin
    sys_rst_in = 1'b1;
    start_in = 1'b0;
    pll_mode_in = 1'b0;
    word_in = 16'h0000;
    for (m = 0; m < 2; m++)
    begin
      do_reset();
      t_align(m[0]);
      if (m == 0)
        t_phase();
      t_data(16'hA5C3);
      t_data(16'h3C5A);
    end
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(25 * 20000);
    bad_count++;
    end_sim();
  end
endmodule
